// >>> bat_pkg.sv
package bat_pkg;
  // ***********************************************************
  // Register map and field layout
  // ***********************************************************
  localparam logic [9:0] OFS_CFG = 10'h000;
  localparam logic [9:0] OFS_LVL = 10'h004;
  localparam logic [9:0] OFS_DMA = 10'h008;
  localparam logic [9:0] OFS_INTC = 10'h00C;
  localparam logic [9:0] OFS_STAT = 10'h010;
  localparam logic [9:0] OFS_RUN_CONTROL = 10'h018;
  localparam logic [9:0] OFS_SMP = 10'h020;
  localparam logic [9:0] OFS_VLD = 10'h060;
  localparam logic [9:0] OFS_USR = 10'h090;
  localparam logic [9:0] OFS_CHS = 10'h0C0;
  localparam int ARR_WORDS = 12;
  localparam int FIFO_DEPTH = 32;
  localparam int DATA_W = 32;
  // Configuration fields
  localparam int CFG_DIV_LSB = 16;
  localparam int CFG_MONO = 8;
  localparam int CFG_FLUSH = 7;
  localparam int CFG_CS = 6;
  localparam int CFG_UD = 5;
  localparam int CFG_VF = 4;
  localparam int CFG_ALIGN = 3;
  localparam int CFG_PACK = 2;
  localparam logic [31:0] CFG_WMASK = 32'h00FF017F;
  localparam logic [1:0] WID_16 = 2'h0;
  localparam logic [1:0] WID_20 = 2'h1;
  // DMA, interrupt control and status fields
  localparam int DMA_EN = 5;
  localparam logic [31:0] DMA_WMASK = 32'h0000003F;
  localparam int INTC_CLR = 16;
  localparam int INTC_THR_LSB = 5;
  localparam int INTC_EIE = 4;
  localparam int INTC_BIE = 3;
  localparam logic [31:0] INTC_WMASK = 32'h000003F8;
  localparam int STAT_E = 4;
  localparam int STAT_B = 3;
  // ***********************************************************
  // Line format
  // ***********************************************************
  localparam logic [7:0] PRE_B = 8'hE8;
  localparam logic [7:0] PRE_M = 8'hE2;
  localparam logic [7:0] PRE_W = 8'hE4;
  localparam logic [7:0] LAST_FRAME = 8'hBF;
  localparam logic [6:0] LAST_HALF = 7'h7F;
  localparam logic [5:0] PRE_HALVES = 6'h08;
endpackage

// >>> bat_top.sv
// Behaviour
// - Frame is two sub-frames; B every 192 frames, otherwise M, then W.
// - Sub-frame has 32 slots; slots 0-3 carry the preamble.
// - Sample in slots 4-27, MSB in 27; 24-bit LSB in slot 4.
// - 20-bit sample in slots 8-27; slots 4-7 are sent as zero.
// - Unused low sample bits are sent as zero.
// - Slot 28 validity, slot 29 user bit, slot 30 channel status.
// - Slot 31 parity makes slots 4-31 hold an even count of ones.
// - Mono without duplicate: second sub-frame validity slot forced to one.
// - Slots 4-31 biphase-mark: toggle each bit start, mid-bit toggle for one.
// - Preamble is eight violating halves, first differs from previous level.
// - Config bit 7 written one flushes core logic; reads as zero.
// - Config bits 6,5,4 enable status, user and validity insertion.
// - Config bit 3 picks right or left justified sample in word.
// - 16-bit with bit 2 set: one word holds two samples.
// - Config bits 1:0 select 16, 20 or 24 bit width.
// - Buffer is 32 words; level register bits 5:0 show count.
// - DMA request while enabled and level at or below watermark.
// - Empty interrupt: threshold 9:5, enable bit 4, status bit 4.
// - Block end interrupt: enable bit 3, status bit 3, clear bit 16.
// - Transfer start bit 0 runs or stops; config is writable while running too.
// - Writes to 0x20 or 0x200-0x3FC push into the buffer.

// ***********************************************************
// Sample buffer
// ***********************************************************
module bat_fifo #(
  parameter int W = 32,
  parameter int D = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  output logic [$clog2(D):0] level
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } bat_fifo_t;
  bat_fifo_t s_ff, nxt_s;
  logic push, pop;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    return (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready = s_ff.cnt < (AW+1)'(D);
  assign out_valid = s_ff.cnt != '0;
  assign out_data = s_ff.mem[s_ff.rp];
  assign level = s_ff.cnt;
  assign push = in_valid & in_ready;
  assign pop = out_ready & out_valid;

  // Pointer and count update; flush wins over traffic
  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.mem[s_ff.wp] = in_data;
      nxt_s.wp = inc(s_ff.wp);
    end
    if (pop) begin
      nxt_s.rp = inc(s_ff.rp);
    end
    nxt_s.cnt = s_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      nxt_s.wp = '0;
      nxt_s.rp = '0;
      nxt_s.cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule

// ***********************************************************
// Transmitter top
// ***********************************************************
module bat_top #(
  parameter int DEPTH = bat_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic dma_tx_req,
  output logic irq,
  output logic audio_out
);
  localparam int LW = $clog2(DEPTH) + 1;
  typedef logic [bat_pkg::ARR_WORDS-1:0][31:0] bat_arr_t;
  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] dma;
    logic [31:0] intc;
    logic blk_flag;
    logic empty_flag;
    logic run;
    logic hold_v;
    logic [31:0] hold;
    logic ap_wr;
    logic [9:0] ap_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic dma_req;
    logic flush;
    bat_arr_t vld;
    bat_arr_t usr;
    bat_arr_t chs;
    logic [7:0] divc;
    logic [6:0] hcnt;
    logic [7:0] frame;
    logic [31:0] word;
    logic [7:0] pre;
    logic inv;
    logic out;
  } bat_state_t;
  bat_state_t s, n;

  logic f_in_valid, f_in_ready, f_out_valid, f_pop;
  logic [31:0] f_in_data, f_out_data;
  logic [LW-1:0] lvl;

  // ***********************************************************
  // Helpers
  // ***********************************************************
  function automatic logic arr_hit(input logic [9:0] a, input logic [9:0] base);
    return (a >= base) && (a < base + 10'(4 * bat_pkg::ARR_WORDS));
  endfunction

  function automatic logic [3:0] arr_idx(input logic [9:0] a, input logic [9:0] base);
    logic [9:0] d;
    d = a - base;
    return d[5:2];
  endfunction

  function automatic logic is_smp(input logic [9:0] a);
    return (a == bat_pkg::OFS_SMP) || a[9];
  endfunction

  function automatic logic arr_bit(input bat_arr_t arr, input logic [8:0] i);
    return arr[i[8:5]][i[4:0]];
  endfunction

  // Sample justified into a 24-bit field whose MSB lands in slot 27
  function automatic logic [23:0] extract(input logic [31:0] w, input logic sub, input logic [31:0] cfg);
    logic [15:0] h;
    logic top;
    top = (cfg[bat_pkg::CFG_PACK]) ? sub : cfg[bat_pkg::CFG_ALIGN];
    h = top ? w[31:16] : w[15:0];
    unique case (cfg[1:0])
      bat_pkg::WID_16: return {h, 8'h00};
      bat_pkg::WID_20: return cfg[bat_pkg::CFG_ALIGN] ? {w[31:12], 4'h0} : {w[19:0], 4'h0};
      default: return cfg[bat_pkg::CFG_ALIGN] ? w[31:8] : w[23:0];
    endcase
  endfunction

  bat_fifo #(.W(bat_pkg::DATA_W), .D(DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .flush(s.flush),
    .in_valid(f_in_valid),
    .in_data(f_in_data),
    .in_ready(f_in_ready),
    .out_valid(f_out_valid),
    .out_data(f_out_data),
    .out_ready(f_pop),
    .level(lvl)
  );

  // ***********************************************************
  // Next state: bus slave, status and line encoder
  // ***********************************************************
  always_comb begin
    logic wr_dp, cap, tick, sub, v_bit;
    logic [5:0] h;
    logic [7:0] reload;
    logic [8:0] aix;
    logic [31:0] w;
    n = s;
    n.flush = 1'b0;
    n.hresp = 1'b0;
    f_pop = 1'b0;
    w = '0;
    v_bit = 1'b0;
    sub = s.hcnt[6];
    h = s.hcnt[5:0];
    aix = {s.frame, sub};
    wr_dp = s.ap_wr & s.hreadyout;
    cap = wr_dp & is_smp(s.ap_addr);
    // Address phase; read data is captured here so it is ready next cycle
    if (hready) begin
      n.ap_wr = hsel & htrans[1] & hwrite;
      n.ap_addr = haddr[9:0];
      n.hrdata = '0;
      if (hsel & htrans[1] & !hwrite) begin
        if (haddr[9:0] == bat_pkg::OFS_CFG) n.hrdata = s.cfg;
        if (haddr[9:0] == bat_pkg::OFS_LVL) n.hrdata = 32'(lvl);
        if (haddr[9:0] == bat_pkg::OFS_DMA) n.hrdata = s.dma;
        if (haddr[9:0] == bat_pkg::OFS_INTC) n.hrdata = s.intc;
        if (haddr[9:0] == bat_pkg::OFS_STAT) n.hrdata = 32'(s.empty_flag) << bat_pkg::STAT_E
                                                     | 32'(s.blk_flag) << bat_pkg::STAT_B;
        if (haddr[9:0] == bat_pkg::OFS_RUN_CONTROL) n.hrdata = 32'(s.run);
        if (arr_hit(haddr[9:0], bat_pkg::OFS_VLD)) n.hrdata = s.vld[arr_idx(haddr[9:0], bat_pkg::OFS_VLD)];
        if (arr_hit(haddr[9:0], bat_pkg::OFS_USR)) n.hrdata = s.usr[arr_idx(haddr[9:0], bat_pkg::OFS_USR)];
        if (arr_hit(haddr[9:0], bat_pkg::OFS_CHS)) n.hrdata = s.chs[arr_idx(haddr[9:0], bat_pkg::OFS_CHS)];
      end
    end
    // Data phase writes; the flush bit is not stored so it reads zero
    if (wr_dp) begin
      if (s.ap_addr == bat_pkg::OFS_CFG) begin
        n.cfg = hwdata & bat_pkg::CFG_WMASK;
        n.flush = hwdata[bat_pkg::CFG_FLUSH];
      end
      if (s.ap_addr == bat_pkg::OFS_DMA) n.dma = hwdata & bat_pkg::DMA_WMASK;
      if (s.ap_addr == bat_pkg::OFS_INTC) n.intc = hwdata & bat_pkg::INTC_WMASK;
      if (s.ap_addr == bat_pkg::OFS_RUN_CONTROL) n.run = hwdata[0];
      if (arr_hit(s.ap_addr, bat_pkg::OFS_VLD)) n.vld[arr_idx(s.ap_addr, bat_pkg::OFS_VLD)] = hwdata;
      if (arr_hit(s.ap_addr, bat_pkg::OFS_USR)) n.usr[arr_idx(s.ap_addr, bat_pkg::OFS_USR)] = hwdata;
      if (arr_hit(s.ap_addr, bat_pkg::OFS_CHS)) n.chs[arr_idx(s.ap_addr, bat_pkg::OFS_CHS)] = hwdata;
      if ((s.ap_addr == bat_pkg::OFS_INTC) && hwdata[bat_pkg::INTC_CLR]) n.blk_flag = 1'b0;
    end
    // Sample pushes go straight in; a full buffer parks the word and stalls the bus
    f_in_valid = s.hold_v | cap;
    f_in_data = s.hold_v ? s.hold : hwdata;
    n.hold = f_in_data;
    n.hold_v = f_in_valid & !f_in_ready;
    // Divider: one half-slot per tick, so the frame takes 128 ticks
    reload = (s.cfg[bat_pkg::CFG_DIV_LSB +: 8] == 8'h00) ? 8'h00 : s.cfg[bat_pkg::CFG_DIV_LSB +: 8] - 8'h01;
    tick = s.run & (s.divc == 8'h00);
    n.divc = tick ? reload : s.divc - 8'h01;
    if (tick) begin
      n.hcnt = s.hcnt + 7'h01;
      if (h == 6'h00) begin
        w[27:4] = f_out_valid ? extract(f_out_data, sub, s.cfg) : 24'h000000;
        v_bit = s.cfg[bat_pkg::CFG_VF] & arr_bit(s.vld, aix);
        w[28] = v_bit | (sub & s.cfg[bat_pkg::CFG_MONO]);
        w[29] = s.cfg[bat_pkg::CFG_UD] & arr_bit(s.usr, aix);
        w[30] = s.cfg[bat_pkg::CFG_CS] & arr_bit(s.chs, aix);
        w[31] = ^w[30:4];
        n.word = w;
        // Packed halves share one entry, so it is only consumed when the second sub-frame is loaded
        f_pop = f_out_valid & (!(s.cfg[bat_pkg::CFG_PACK] && s.cfg[1:0] == bat_pkg::WID_16) | sub);
        n.pre = sub ? bat_pkg::PRE_W : ((s.frame == 8'h00) ? bat_pkg::PRE_B : bat_pkg::PRE_M);
        n.inv = s.out;
        n.out = n.pre[7] ^ s.out;
      end else if (h < bat_pkg::PRE_HALVES) begin
        n.out = s.pre[3'h7 - h[2:0]] ^ s.inv;
      end else if (!h[0]) begin
        n.out = ~s.out;
      end else begin
        n.out = s.out ^ s.word[h[5:1]];
      end
      if (s.hcnt == bat_pkg::LAST_HALF) begin
        n.frame = (s.frame == bat_pkg::LAST_FRAME) ? 8'h00 : s.frame + 8'h01;
        if (s.frame == bat_pkg::LAST_FRAME) n.blk_flag = 1'b1;
      end
    end
    // Stop or flush restarts at the block start
    if (!s.run | s.flush) begin
      n.divc = 8'h00;
      n.hcnt = '0;
      n.frame = 8'h00;
    end
    if (s.flush) begin
      n.hold_v = 1'b0;
      n.out = 1'b0;
    end
    n.hreadyout = !n.hold_v;
    n.empty_flag = lvl < LW'(s.intc[bat_pkg::INTC_THR_LSB +: 5]);
    n.dma_req = s.dma[bat_pkg::DMA_EN] & (lvl <= LW'(s.dma[4:0]));
    n.irq = (n.empty_flag & n.intc[bat_pkg::INTC_EIE]) | (n.blk_flag & n.intc[bat_pkg::INTC_BIE]);
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.hreadyout <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;
  assign dma_tx_req = s.dma_req;
  assign irq = s.irq;
  assign audio_out = s.out;

  // ***********************************************************
  // Checks
  // ***********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic tk;
  assign tk = s.run & (s.divc == 8'h00) & !s.flush;

  property p_pre_first;
    tk & (s.hcnt[5:0] == 6'h00) |=> s.out != $past(s.out);
  endproperty
  a_pre_first: assert property (p_pre_first) else $error("preamble start did not toggle");
  property p_bmc_edge;
    tk & (s.hcnt[5:0] >= bat_pkg::PRE_HALVES) & !s.hcnt[0] |=> s.out != $past(s.out);
  endproperty
  a_bmc_edge: assert property (p_bmc_edge) else $error("no toggle at bit boundary");
  property p_parity;
    tk & (s.hcnt[5:0] == 6'h01) |-> ^s.word[31:4] == 1'b0;
  endproperty
  a_parity: assert property (p_parity) else $error("odd parity in sub-frame");
  property p_block;
    tk & (s.hcnt == bat_pkg::LAST_HALF) & (s.frame == bat_pkg::LAST_FRAME) |=> s.blk_flag && s.frame == 8'h00;
  endproperty
  a_block: assert property (p_block) else $error("block end not flagged");
  property p_preamble_b;
    tk & (s.hcnt == 7'h00) & (s.frame == 8'h00) |=> s.pre == bat_pkg::PRE_B;
  endproperty
  a_preamble_b: assert property (p_preamble_b) else $error("block start lacks preamble B");
  property p_flush;
    s.flush |=> lvl == '0 && s.hcnt == '0 && s.hreadyout;
  endproperty
  a_flush: assert property (p_flush) else $error("flush left state behind");
  property p_dma;
    s.dma_req |-> $past(s.dma[bat_pkg::DMA_EN]) && $past(lvl) <= LW'($past(s.dma[4:0]));
  endproperty
  a_dma: assert property (p_dma) else $error("dma request without cause");
  property p_empty;
    (lvl >= LW'(s.intc[9:5])) [*2] |-> !s.empty_flag;
  endproperty
  a_empty: assert property (p_empty) else $error("empty status above threshold");
  property p_irq;
    s.irq |-> (s.empty_flag & s.intc[bat_pkg::INTC_EIE]) | (s.blk_flag & s.intc[bat_pkg::INTC_BIE]);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without enabled status");

  c_block: cover property (tk & (s.hcnt == bat_pkg::LAST_HALF) & (s.frame == bat_pkg::LAST_FRAME));
  c_stall: cover property (!s.hreadyout ##1 s.hreadyout);
  c_dma: cover property (s.dma_req);
  c_irq: cover property (s.irq);
endmodule

// >>> bat_rx_model.sv
// ********
// Far-end receiver
// ********
module bat_rx_model (
  input wire logic clk,
  input wire logic listen,
  input wire logic line,
  output logic sf_valid,
  output logic [7:0] sf_pre,
  output logic [27:0] sf_bits,
  output logic [15:0] code_errs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hist_ff = 3'h0;
  logic [63:0] hv_ff = 64'h0;
  int cnt_ff = 0;

  // Quiet outputs until the first sub-frame is decoded
  initial begin
    sf_valid = 1'b0;
    sf_pre = 8'h0;
    sf_bits = 28'h0;
    code_errs = 16'h0;
  end

  // Split one sub-frame into a polarity-free preamble code and slots 4..31
  task automatic decode(input logic [63:0] s);
    logic [7:0] p;
    logic [27:0] b;
    int e;
    e = 0;
    for (int k = 0; k < 8; k++) p[7-k] = s[k] ~^ s[0];
    for (int k = 4; k < 32; k++) begin
      if (s[2*k] == s[2*k-1]) e++;
      b[k-4] = s[2*k] ^ s[2*k+1];
    end
    if (^b) e++;
    if (p != bat_pkg::PRE_B && p != bat_pkg::PRE_M && p != bat_pkg::PRE_W) e++;
    code_errs <= code_errs + 16'(e);
    sf_pre <= p;
    sf_bits <= b;
    sf_valid <= 1'b1;
  endtask

  // Lock on three equal halves; valid biphase data never shows them, so no false lock
  always @(posedge clk) begin
    sf_valid <= 1'b0;
    hist_ff <= {hist_ff[1:0], line};
    if (!listen) begin
      cnt_ff <= 0;
    end else if (cnt_ff == 0) begin
      if (hist_ff[1:0] == {2{line}} && hist_ff[2] != line) begin
        hv_ff <= {61'h0, line, hist_ff[0], hist_ff[1]};
        cnt_ff <= 3;
      end
    end else begin
      hv_ff[cnt_ff] <= line;
      cnt_ff <= (cnt_ff == 63) ? 0 : cnt_ff + 1;
      if (cnt_ff == 63) decode({line, hv_ff[62:0]});
    end
  end
endmodule

// >>> tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Bench signals
  // ********
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic listen = 1'b0;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout, hresp, dma_tx_req, irq, audio_out, sf_valid;
  logic [7:0] sf_pre;
  logic [27:0] sf_bits;
  logic [15:0] code_errs;
  int err_count = 0;
  int comparisons = 0;
  int stall_cyc = 0;

  // 125 MHz clock; the single slave sees its own ready
  always #4 clk = ~clk;
  assign hready = hreadyout;

  bat_top #(.DEPTH(32)) bat_top_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .dma_tx_req(dma_tx_req), .irq(irq), .audio_out(audio_out));
  bat_rx_model bat_rx_model_i (.clk(clk), .listen(listen), .line(audio_out), .sf_valid(sf_valid),
    .sf_pre(sf_pre), .sf_bits(sf_bits), .code_errs(code_errs));

  // ********
  // Bus and check tasks
  // ********
  task automatic complete_run();
    $display("Counts: comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic timed_out();
    chk_bit(1'b0, 1'b1);
    complete_run();
  endtask
  // One AHB transfer; a stretched address phase keeps the address standing, a stretched data phase only the write data
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, a};
    do begin
      @(posedge clk);
      n++;
      if (hreadyout !== 1'b1) stall_cyc++;
    end while (hreadyout !== 1'b1 && n < 20000);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
      n++;
      if (hreadyout !== 1'b1) stall_cyc++;
    end while (hreadyout !== 1'b1 && n < 20000);
    rd = hrdata;
    if (n >= 20000) timed_out();
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk_word(r, e);
    chk_bit(hresp, 1'b0);
  endtask
  // Wait for the receiver's next sub-frame and compare it whole, parity worked out here
  task automatic expect_sf(input logic [7:0] p, input logic [23:0] s, input logic [2:0] cuv);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sf_valid !== 1'b1 && n < 1000);
    if (n >= 1000) timed_out();
    chk_word({24'h0, sf_pre}, {24'h0, p});
    chk_word({4'h0, sf_bits}, {4'h0, ^{cuv, s}, cuv, s});
  endtask
  task automatic go();
    listen <= 1'b1;
    wr(bat_pkg::OFS_RUN_CONTROL, 32'h1);
  endtask
  task automatic stop();
    wr(bat_pkg::OFS_RUN_CONTROL, 32'h0);
    listen <= 1'b0;
    chk_word({16'h0, code_errs}, 32'h0);
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_regs();
    logic [9:0] ofs [10];
    ofs = '{bat_pkg::OFS_CFG, bat_pkg::OFS_LVL, bat_pkg::OFS_DMA, bat_pkg::OFS_INTC, bat_pkg::OFS_STAT,
      bat_pkg::OFS_RUN_CONTROL, bat_pkg::OFS_SMP, bat_pkg::OFS_VLD, bat_pkg::OFS_USR, bat_pkg::OFS_CHS};
    foreach (ofs[i]) rdchk(ofs[i], 32'h0);
    wr(bat_pkg::OFS_CFG, 32'hFFFFFFFF);
    rdchk(bat_pkg::OFS_CFG, 32'h00FF017F);
    wr(bat_pkg::OFS_DMA, 32'hFFFFFFFF);
    rdchk(bat_pkg::OFS_DMA, 32'h0000003F);
    wr(bat_pkg::OFS_INTC, 32'hFFFFFFFF);
    rdchk(bat_pkg::OFS_INTC, 32'h000003F8);
    wr(bat_pkg::OFS_LVL, 32'hFFFFFFFF);
    rdchk(bat_pkg::OFS_LVL, 32'h0);
    wr(10'h0EC, 32'hA5A55A5A);
    rdchk(10'h0EC, 32'hA5A55A5A);
    rdchk(10'h03C, 32'h0);
    wr(bat_pkg::OFS_CFG, 32'h0);
    wr(bat_pkg::OFS_DMA, 32'h0);
    wr(bat_pkg::OFS_INTC, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_pcm24();
    wr(bat_pkg::OFS_VLD, 32'h5);
    wr(bat_pkg::OFS_USR, 32'h2);
    wr(bat_pkg::OFS_CHS, 32'hC);
    wr(bat_pkg::OFS_CFG, 32'h00010072);
    wr(bat_pkg::OFS_SMP, 32'hAB123456);
    wr(bat_pkg::OFS_SMP, 32'h00654321);
    wr(bat_pkg::OFS_SMP, 32'h00800001);
    wr(bat_pkg::OFS_SMP, 32'h007FFFFE);
    go();
    expect_sf(bat_pkg::PRE_B, 24'h123456, 3'h1);
    expect_sf(bat_pkg::PRE_W, 24'h654321, 3'h2);
    expect_sf(bat_pkg::PRE_M, 24'h800001, 3'h5);
    expect_sf(bat_pkg::PRE_W, 24'h7FFFFE, 3'h4);
    stop();
    $display("test pcm24 done");
  endtask
  task automatic t_pcm20();
    wr(bat_pkg::OFS_CFG, 32'h00010009);
    wr(bat_pkg::OFS_SMP, 32'hFEDCBA98);
    wr(bat_pkg::OFS_SMP, 32'h00001FFF);
    go();
    expect_sf(bat_pkg::PRE_B, 24'hFEDCB0, 3'h0);
    expect_sf(bat_pkg::PRE_W, 24'h000010, 3'h0);
    stop();
    $display("test pcm20 done");
  endtask
  task automatic t_pack16();
    wr(bat_pkg::OFS_CFG, 32'h00010104);
    wr(bat_pkg::OFS_SMP, 32'h1234ABCD);
    wr(bat_pkg::OFS_SMP, 32'h80007FFF);
    go();
    expect_sf(bat_pkg::PRE_B, 24'hABCD00, 3'h0);
    expect_sf(bat_pkg::PRE_W, 24'h123400, 3'h1);
    expect_sf(bat_pkg::PRE_M, 24'h7FFF00, 3'h0);
    expect_sf(bat_pkg::PRE_W, 24'h800000, 3'h1);
    stop();
    $display("test pack16 done");
  endtask
  // Level, watermark and threshold edges, then fill past full and drain
  task automatic t_buffer();
    logic [31:0] r;
    r = 32'hFFFFFFFF;
    wr(bat_pkg::OFS_CFG, 32'h80);
    wr(bat_pkg::OFS_DMA, 32'h24);
    wr(bat_pkg::OFS_INTC, 32'h70);
    repeat (3) @(posedge clk);
    chk_bit(dma_tx_req, 1'b1);
    chk_bit(irq, 1'b1);
    rdchk(bat_pkg::OFS_STAT, 32'h10);
    for (int i = 0; i < 3; i++) wr(10'h200 + 10'(4 * i), 32'h1);
    @(posedge clk); // Status trails the level by one cycle
    rdchk(bat_pkg::OFS_STAT, 32'h0);
    chk_bit(irq, 1'b0);
    chk_bit(dma_tx_req, 1'b1);
    wr(bat_pkg::OFS_SMP, 32'h2);
    wr(10'h3FC, 32'h3);
    rdchk(bat_pkg::OFS_LVL, 32'h5);
    chk_bit(dma_tx_req, 1'b0);
    wr(bat_pkg::OFS_CFG, 32'h80);
    @(posedge clk); // Flush pulse acts a cycle after the write
    rdchk(bat_pkg::OFS_LVL, 32'h0);
    for (int i = 0; i < 32; i++) wr(bat_pkg::OFS_SMP, 32'(i));
    rdchk(bat_pkg::OFS_LVL, 32'h20);
    wr(bat_pkg::OFS_CFG, 32'h00040002);
    stall_cyc = 0;
    wr(bat_pkg::OFS_RUN_CONTROL, 32'h1);
    for (int i = 0; i < 3; i++) wr(bat_pkg::OFS_SMP, 32'h5);
    chk_bit(stall_cyc > 0, 1'b1);
    for (int i = 0; i < 100 && r !== 32'h0; i++) begin
      repeat (200) @(posedge clk);
      bus(1'b0, bat_pkg::OFS_LVL, 32'h0, r);
    end
    chk_word(r, 32'h0);
    if (r !== 32'h0) complete_run(); // Drain never finished
    rdchk(bat_pkg::OFS_STAT, 32'h10);
    wr(bat_pkg::OFS_RUN_CONTROL, 32'h0);
    wr(bat_pkg::OFS_DMA, 32'h0);
    wr(bat_pkg::OFS_INTC, 32'h0);
    wr(bat_pkg::OFS_CFG, 32'h80);
    $display("test buffer done");
  endtask
  // A whole 192-frame block: B only at its start, then sticky end flag and its clear
  task automatic t_block();
    wr(bat_pkg::OFS_INTC, 32'h8);
    wr(bat_pkg::OFS_CFG, 32'h00010002);
    go();
    for (int i = 0; i <= 384; i++) begin
      expect_sf((i % 384 == 0) ? bat_pkg::PRE_B : (i % 2 == 1) ? bat_pkg::PRE_W : bat_pkg::PRE_M,
        24'h0, 3'h0);
    end
    chk_bit(irq, 1'b1);
    rdchk(bat_pkg::OFS_STAT, 32'h8);
    wr(bat_pkg::OFS_INTC, 32'h00010008);
    rdchk(bat_pkg::OFS_STAT, 32'h0);
    chk_bit(irq, 1'b0);
    stop();
    $display("test block done");
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_pcm24();
    t_pcm20();
    t_pack16();
    t_buffer();
    t_block();
    complete_run();
  end
endmodule
